// >>> rtl/mscfg_top.sv
/*
 Miscellaneous configuration register with AXI4-Lite slave, driving regulator,
 calibration range, shared pin routing and standby keep-alive controls.
 Assumes a single 25 MHz clock; standby and error-enable inputs come from the
 same clock domain.
*/
`timescale 1ns/100ps
`include "mscfg_map.svh"
module mscfg_top
   import mscfg_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Device state and settings from elsewhere in the converter
   input wire logic in_standby,
   input wire logic diag_any_en,
   input wire logic osc_dep_err_en,
   input wire logic clk_sel_internal,
   input wire logic shared_pin_output_enable,
   input wire logic shared_pin_output_level,
   // Controls to the analog side
   output logic analog_regulator_power_down,
   output logic calibration_range_double,
   output logic diag_active_q,
   output logic osc_run_q,
   // Shared output pin
   output logic shared_output_pin_o,
   output logic shared_output_pin_oe
);
   logic [15:0] misc_q;
   mscfg_ctrl_t ctrl;
   mscfg_pin_t gpo;
   mscfg_pin_t pin_q;
   logic aw_held_q, w_held_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [15:0] wmerge;
   logic do_write;
   mscfg_state_t rd_state_q;
   // Word indices compared against the 10-bit word part of the bus address
   localparam logic [9:0] misc_word = 10'(`MSCFG_MISC_ADDR >> 2);
   localparam logic [9:0] status_word = 10'(`MSCFG_STATUS_ADDR >> 2);

   assign ctrl.analog_regulator_power_down = misc_q[`MSCFG_BIT_PD_REG];
   assign ctrl.calibration_range_double = misc_q[`MSCFG_BIT_CAL_X2];
   assign ctrl.standby_output_route_enable = misc_q[`MSCFG_BIT_STBY_OUT];
   assign ctrl.standby_diagnostics_keep_alive = misc_q[`MSCFG_BIT_STBY_DIAG];
   assign gpo = '{oe: shared_pin_output_enable, level: shared_pin_output_level};

   // Write: address and data captured in either order, then one response
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   always_comb begin
      wmerge = misc_q;
      if (wstrb_q[0]) begin
         wmerge[7:0] = wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
         wmerge[15:8] = wdata_q[15:8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         misc_q <= `MSCFG_MISC_RESET;
      end else if (do_write && awaddr_q[11:2] == misc_word) begin
         // Bit 15 is stored as written; software keeps it zero
         misc_q <= wmerge & `MSCFG_MISC_WMASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MSCFG_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_q[11:2] == misc_word) begin
            s_axi_bresp <= `MSCFG_RESP_OKAY;
         end else begin
            s_axi_bresp <= `MSCFG_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read: one transfer at a time, answered the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= MSCFG_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `MSCFG_RESP_OKAY;
      end else begin
         unique case (rd_state_q)
            MSCFG_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  rd_state_q <= MSCFG_RESP;
                  s_axi_rresp <= `MSCFG_RESP_OKAY;
                  if (s_axi_araddr[11:2] == misc_word) begin
                     s_axi_rdata <= {16'h0000, misc_q};
                  end else if (s_axi_araddr[11:2] == status_word) begin
                     s_axi_rdata <= {28'h0000000, osc_run_q, diag_active_q,
                                     shared_output_pin_oe, shared_output_pin_o};
                  end else begin
                     s_axi_rdata <= '0;
                     s_axi_rresp <= `MSCFG_RESP_SLVERR;
                  end
               end
            end
            MSCFG_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_q <= MSCFG_IDLE;
               end
            end
         endcase
      end
   end

   // Analog controls registered from the stored fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_regulator_power_down <= 1'b0;
         calibration_range_double <= 1'b0;
      end else begin
         analog_regulator_power_down <= ctrl.analog_regulator_power_down;
         calibration_range_double <= ctrl.calibration_range_double;
      end
   end

   mscfg_pin_mux u_pin_mux (
      .aclk(aclk),
      .aresetn(aresetn),
      .route_en(ctrl.standby_output_route_enable),
      .in_standby(in_standby),
      .gpo(gpo),
      .pin_q(pin_q)
   );

   assign shared_output_pin_o = pin_q.level;
   assign shared_output_pin_oe = pin_q.oe;

   mscfg_osc_keep u_osc_keep (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_standby(in_standby),
      .diag_keep(ctrl.standby_diagnostics_keep_alive),
      .diag_any_en(diag_any_en),
      .osc_dep_err_en(osc_dep_err_en),
      .clk_sel_internal(clk_sel_internal),
      .diag_active_q(diag_active_q),
      .osc_run_q(osc_run_q)
   );
endmodule

// >>> rtl/mscfg_map.svh
/*
 Register offsets, field positions, reset values for the miscellaneous configuration register.
 Assumes inclusion by name from design files; definitions only.
*/
`ifndef MSCFG_MAP_SVH
`define MSCFG_MAP_SVH

// Printed index and byte address on the 32-bit bus
`define MSCFG_MISC_INDEX 8'h39
`define MSCFG_MISC_ADDR 12'he4
`define MSCFG_STATUS_ADDR 12'he8
`define MSCFG_MISC_RESET 16'h0000
// Writable bits: 15, 14, 13, 8, 7 (bits 6..0 beyond this block read zero)
`define MSCFG_MISC_WMASK 16'he180
`define MSCFG_BIT_RSVD15 15
`define MSCFG_BIT_PD_REG 14
`define MSCFG_BIT_CAL_X2 13
`define MSCFG_BIT_STBY_OUT 8
`define MSCFG_BIT_STBY_DIAG 7
`define MSCFG_RESP_OKAY 2'b00
`define MSCFG_RESP_SLVERR 2'b10

`endif

// >>> rtl/mscfg_pkg.sv
/*
 Types for the miscellaneous configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mscfg_pkg;
   typedef struct packed {
      logic analog_regulator_power_down;
      logic calibration_range_double;
      logic standby_output_route_enable;
      logic standby_diagnostics_keep_alive;
   } mscfg_ctrl_t;

   typedef struct packed {
      logic oe;
      logic level;
   } mscfg_pin_t;

   typedef enum logic [1:0] {MSCFG_IDLE, MSCFG_RESP} mscfg_state_t;
endpackage

// >>> rtl/mscfg_pin_mux.sv
/*
 Shared output pin selection between general-purpose output and standby indication.
 Assumes same-clock inputs; result is registered.
*/
`timescale 1ns/100ps
module mscfg_pin_mux
   import mscfg_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Selection
   input wire logic route_en,
   input wire logic in_standby,
   input wire mscfg_pin_t gpo,
   // Pin
   output mscfg_pin_t pin_q
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= '0;
      end else if (route_en) begin
         // Active-low standby indication overrides gpo settings
         pin_q <= '{oe: 1'b1, level: !in_standby};
      end else begin
         pin_q <= gpo;
      end
   end
endmodule

// >>> rtl/mscfg_osc_keep.sv
/*
 Standby keep-alive decisions for diagnostics and the internal oscillator.
 Assumes same-clock inputs; results registered.
*/
`timescale 1ns/100ps
module mscfg_osc_keep (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Conditions
   input wire logic in_standby,
   input wire logic diag_keep,
   input wire logic diag_any_en,
   input wire logic osc_dep_err_en,
   input wire logic clk_sel_internal,
   // Results
   output logic diag_active_q,
   output logic osc_run_q
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         diag_active_q <= 1'b0;
      end else begin
         diag_active_q <= diag_any_en && (!in_standby || diag_keep);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_run_q <= 1'b0;
      end else if (in_standby) begin
         // Stop the oscillator unless every keep-alive condition holds
         osc_run_q <= diag_keep && osc_dep_err_en && clk_sel_internal;
      end else begin
         osc_run_q <= clk_sel_internal;
      end
   end
endmodule

// >>> bench/mscfg_chk.sv
/*
 Port assertions for the miscellaneous configuration block.
 Assumes binding to mscfg_top with one clock and synchronous reset.
*/
`timescale 1ns/100ps
module mscfg_chk (
   // Clock, reset, bus
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   // Device state
   input wire logic in_standby,
   input wire logic diag_any_en,
   input wire logic osc_dep_err_en,
   input wire logic clk_sel_internal,
   input wire logic shared_pin_output_enable,
   // Outputs
   input wire logic analog_regulator_power_down,
   input wire logic calibration_range_double,
   input wire logic diag_active_q,
   input wire logic osc_run_q,
   input wire logic shared_output_pin_o,
   input wire logic shared_output_pin_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_reset_clear: assert property ($rose(aresetn) |->
      !analog_regulator_power_down && !calibration_range_double && !osc_run_q)
      else $error("controls not clear after reset");
   chk_pin_route: assert property (shared_output_pin_oe && !$past(shared_pin_output_enable)
      |-> shared_output_pin_o == !$past(in_standby)) else $error("routed pin level wrong");
   chk_osc_standby: assert property (osc_run_q && $past(in_standby)
      |-> $past(osc_dep_err_en && clk_sel_internal)) else $error("oscillator kept wrongly");
   chk_osc_awake: assert property (!$past(in_standby) && $past(aresetn)
      |-> osc_run_q == $past(clk_sel_internal)) else $error("oscillator wrong when awake");
   chk_diag_standby: assert property (diag_active_q && $past(in_standby)
      |-> $past(diag_any_en)) else $error("diagnostics kept wrongly");
   chk_busy_readys: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
      else $error("ready high while response pending");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
   chk_ctrl_by_write: assert property ($changed(analog_regulator_power_down)
      || $changed(calibration_range_double) |-> !s_axi_awready)
      else $error("control changed without write");

   cover property (osc_run_q && in_standby);
   cover property (shared_output_pin_oe && !shared_pin_output_enable);
   cover property (s_axi_bvalid);
endmodule

bind mscfg_top mscfg_chk u_chk (.*);

// >>> bench/mscfg_tb_top.sv
/*
 Self-checking bench for the miscellaneous configuration block.
 Assumes mscfg_top and the checker bind; drives AXI4-Lite as master.
*/
`timescale 1ns/100ps
`include "mscfg_map.svh"
module mscfg_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, in_standby, diag_any_en, osc_dep_err_en, clk_sel_internal;
   logic shared_pin_output_enable, shared_pin_output_level, analog_regulator_power_down;
   logic calibration_range_double, diag_active_q, osc_run_q;
   logic shared_output_pin_o, shared_output_pin_oe;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [31:0] wv [4] = '{32'h7fff, 32'h4000, 32'h2000, 32'h0000};
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   int n_fail = 0, total_checks = 0, cyc = 0;

   mscfg_top u_dut (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail = n_fail + 1;
         report_and_stop;
      end
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task rd_reg(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Lets registered outputs follow a changed input or register
   task settle;
      repeat (3) @(posedge aclk);
      #1;
   endtask

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {in_standby, diag_any_en, osc_dep_err_en, clk_sel_internal} = '0;
      {shared_pin_output_enable, shared_pin_output_level} = '0;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(`MSCFG_MISC_ADDR);
      chk("reset", 32'h0, rdat);
      for (int i = 0; i < 4; i++) begin
         wr(`MSCFG_MISC_ADDR, wv[i]);
         chk("bresp", `MSCFG_RESP_OKAY, rsp);
         settle;
         chk("regulator", wv[i][14], analog_regulator_power_down);
         chk("cal", wv[i][13], calibration_range_double);
         rd_reg(`MSCFG_MISC_ADDR);
         chk("misc", wv[i] & {16'h0, `MSCFG_MISC_WMASK}, rdat);
      end
      wr(12'h010, 32'h6180);
      chk("bad bresp", `MSCFG_RESP_SLVERR, rsp);
      rd_reg(12'h010);
      chk("bad rresp", `MSCFG_RESP_SLVERR, rsp);
      rd_reg(`MSCFG_MISC_ADDR);
      chk("kept", 32'h0, rdat);
      wr(`MSCFG_MISC_ADDR, 32'h0100);
      for (int s = 0; s < 2; s++) begin
         in_standby <= s[0];
         settle;
         chk("pin oe", 1, shared_output_pin_oe);
         chk("pin lvl", !s[0], shared_output_pin_o);
         rd_reg(`MSCFG_STATUS_ADDR);
         chk("status", {30'h0, 1'b1, !s[0]}, rdat);
      end
      wr(`MSCFG_MISC_ADDR, 32'h0);
      for (int g = 0; g < 4; g++) begin
         {shared_pin_output_enable, shared_pin_output_level} <= g[1:0];
         settle;
         chk("gpo oe", g[1], shared_output_pin_oe);
         if (g[1]) chk("gpo lvl", g[0], shared_output_pin_o);
      end
      for (int d = 0; d < 2; d++) begin
         wr(`MSCFG_MISC_ADDR, d[0] ? 32'h0080 : 32'h0);
         for (int c = 0; c < 16; c++) begin
            {in_standby, diag_any_en, osc_dep_err_en, clk_sel_internal} <= c[3:0];
            settle;
            chk("osc", c[3] ? d[0] & c[1] & c[0] : c[0], osc_run_q);
            chk("diag", c[3] ? d[0] & c[2] : c[2], diag_active_q);
         end
      end
      report_and_stop;
   end
endmodule
